/* File: core/conv_pkg.sv */
// constants shared by the conversion handshake and its result buffer
package conv_pkg;
  localparam int unsigned RESULT_WIDTH   = 12;  // bits per converter word
  localparam int unsigned DIV_WIDTH      = 4;   // width of the divider setting
  localparam int unsigned COMP_COUNT     = 3;   // comparators
  localparam int unsigned SAMPLE_TICKS   = 10;  // divided ticks of sampling
  localparam int unsigned SAMPLE_SLACK   = 6;   // fabric cycles allowed on top
  localparam int unsigned CONVERT_TICKS  = 34;  // divided ticks of conversion
  localparam int unsigned CONVERT_SLACK  = 16;  // fabric cycles allowed on top
  localparam int unsigned SETTLE_CYCLES  = 8;   // quiet cycles after busy falls
  localparam int unsigned CAL_TICKS      = 16;  // divided ticks of calibration
  localparam int unsigned FIFO_DEPTH     = 8;   // result buffer entries
  localparam int unsigned CNT_WIDTH      = 6;   // phase counter width
  localparam int unsigned CAL_WIDTH      = 5;   // calibration counter width
  localparam int unsigned BOUND_WIDTH    = 10;  // phase length helper width
  localparam logic [CNT_WIDTH-1:0] SAMPLE_LAST  = CNT_WIDTH'(SAMPLE_TICKS - 1);
  localparam logic [CNT_WIDTH-1:0] CONVERT_LAST = CNT_WIDTH'(CONVERT_TICKS - 1);
  localparam logic [CNT_WIDTH-1:0] SETTLE_LAST  = CNT_WIDTH'(SETTLE_CYCLES - 1);
  localparam logic [CAL_WIDTH-1:0] CAL_LAST     = CAL_WIDTH'(CAL_TICKS - 1);
  localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 12'h000;  // words after reset
  localparam logic [2:0]           SYNC_RESET   = 3'h0;        // synchroniser reset
  // conversion sequencer states
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_SAMPLE  = 4'h2,
    ST_CONVERT = 4'h4,
    ST_SETTLE  = 4'h8
  } conv_state_type;
endpackage

/* File: core/dual_conv_handshake.sv */
// conversion handshake, result buffer and comparators of a paired converter
`timescale 1ns/1ps
`default_nettype none
module dual_conv_handshake #(
  parameter logic [2:0] COMPARATOR_SOURCE = 3'h0  // 1 = dedicated input
) (
  input  wire logic                                 mclk,
  input  wire logic                                 srst,
  input  wire logic [conv_pkg::DIV_WIDTH-1:0]       converter_clock_divider,
  input  wire logic                                 start_conversion,
  input  wire logic                                 stop_conversion,
  input  wire logic                                 converter_reset_n,
  input  wire logic [conv_pkg::RESULT_WIDTH-1:0]    converter_a_sample,
  input  wire logic [conv_pkg::RESULT_WIDTH-1:0]    converter_b_sample,
  input  wire logic [conv_pkg::COMP_COUNT-1:0]      channel_compare_raw,
  input  wire logic [conv_pkg::COMP_COUNT-1:0]      dedicated_compare_raw,
  output logic                                      conversion_in_progress,
  output logic                                      end_of_conversion,
  output logic [conv_pkg::RESULT_WIDTH-1:0]         converter_a_result,
  output logic [conv_pkg::RESULT_WIDTH-1:0]         converter_b_result,
  output logic                                      calibration_ready,
  output logic [conv_pkg::COMP_COUNT-1:0]           compare_level,
  output logic [conv_pkg::COMP_COUNT-1:0]           compare_latched,
  output logic                                      result_valid,
  input  wire logic                                 result_ready,
  output logic [conv_pkg::RESULT_WIDTH-1:0]         first_result_word,
  output logic [conv_pkg::RESULT_WIDTH-1:0]         second_result_word
);
  import conv_pkg::*;

  // converter tick divider
  logic [DIV_WIDTH-1:0] div_q, div_d;   // cycle count within a tick
  logic [DIV_WIDTH-1:0] div_last;       // last count of a tick
  logic                 tick_q, tick_d; // one-cycle converter tick

  // a setting of zero behaves like one
  assign div_last = (converter_clock_divider == '0) ? '0 : converter_clock_divider - 1'b1;

  // tick every divider cycles
  always_comb begin
    div_d  = div_q + 1'b1;
    tick_d = 1'b0;
    if (div_q >= div_last) begin
      div_d  = '0;
      tick_d = 1'b1;  // phase free-runs against handshake
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  // converter reset pin synchroniser
  logic [2:0] rsn_q, rsn_d;       // three flops, index 0 first
  logic       rsn_lvl_q, rsn_lvl_d; // agreed level
  logic       conv_reset;          // calibration and latches held clear

  always_comb begin
    rsn_d     = {rsn_q[1:0], converter_reset_n};
    rsn_lvl_d = (rsn_q[1] == rsn_q[2]) ? rsn_q[2] : rsn_lvl_q;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rsn_q     <= SYNC_RESET;
      rsn_lvl_q <= 1'b0;
    end else begin
      rsn_q     <= rsn_d;
      rsn_lvl_q <= rsn_lvl_d;
    end
  end

  assign conv_reset = !rsn_lvl_q;

  // calibration sequence
  logic [CAL_WIDTH-1:0] cal_q, cal_d; // ticks spent calibrating
  logic                 cal_rdy_q, cal_rdy_d;

  always_comb begin
    cal_d     = cal_q;
    cal_rdy_d = cal_rdy_q;
    if (conv_reset) begin  // calibration restarts
      cal_d     = '0;
      cal_rdy_d = 1'b0;
    end else if (!cal_rdy_q && tick_q) begin
      cal_d = cal_q + 1'b1;
      if (cal_q == CAL_LAST) begin
        cal_rdy_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cal_q     <= '0;
      cal_rdy_q <= 1'b0;
    end else begin
      cal_q     <= cal_d;
      cal_rdy_q <= cal_rdy_d;
    end
  end

  assign calibration_ready = cal_rdy_q;

  // result buffer
  stream_if #(.WIDTH(2 * RESULT_WIDTH)) push_if ();
  stream_if #(.WIDTH(2 * RESULT_WIDTH)) pop_if ();

  result_fifo #(
    .WIDTH (2 * RESULT_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .srst     (srst),
    .in_port  (push_if),
    .out_port (pop_if)
  );

  // conversion sequencer
  conv_state_type          st_q, st_d;         // shared by both converters
  logic [CNT_WIDTH-1:0]    cnt_q, cnt_d;       // ticks or settle cycles
  logic [RESULT_WIDTH-1:0] cap_a_q, cap_a_d;   // held sample, converter a
  logic [RESULT_WIDTH-1:0] cap_b_q, cap_b_d;   // held sample, converter b
  logic [RESULT_WIDTH-1:0] res_a_q, res_a_d;   // published result a
  logic [RESULT_WIDTH-1:0] res_b_q, res_b_d;   // published result b
  logic                    eoc_q, eoc_d;       // done pulse
  logic                    start_ok;           // a start may be taken

  // buffer room stalls new starts, so a finished pair always fits
  assign start_ok = cal_rdy_q && push_if.ready && !stop_conversion;

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    cap_a_d = cap_a_q;
    cap_b_d = cap_b_q;
    res_a_d = res_a_q;
    res_b_d = res_b_q;
    eoc_d   = 1'b0;
    // track both inputs throughout sampling, and in conversion while start is held
    if (st_q == ST_SAMPLE || (st_q == ST_CONVERT && start_conversion)) begin
      cap_a_d = converter_a_sample;  // one sequence for both
      cap_b_d = converter_b_sample;
    end
    unique case (st_q)
      ST_IDLE: begin
        // start sampled on the fabric clock
        if (start_conversion && start_ok) begin
          st_d  = ST_SAMPLE;
          cnt_d = '0;
        end
      end
      ST_SAMPLE: begin
        if (stop_conversion) begin  // abort
          st_d  = ST_SETTLE;
          cnt_d = '0;
        end else if (tick_q) begin
          if (cnt_q == SAMPLE_LAST) begin
            st_d  = ST_CONVERT;
            cnt_d = '0;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
      end
      ST_CONVERT: begin
        // restarts are ignored here
        if (stop_conversion) begin  // abort, results kept
          st_d  = ST_SETTLE;
          cnt_d = '0;
        end else if (tick_q && !start_conversion) begin
          if (cnt_q == CONVERT_LAST) begin
            st_d    = ST_SETTLE;
            cnt_d   = '0;
            res_a_d = cap_a_q;  // both words with the pulse
            res_b_d = cap_b_q;
            eoc_d   = 1'b1;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
      end
      ST_SETTLE: begin
        // quiet time before another start is taken
        if (cnt_q == SETTLE_LAST) begin
          st_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q    <= ST_IDLE;
      cnt_q   <= '0;
      cap_a_q <= RESULT_RESET;
      cap_b_q <= RESULT_RESET;
      res_a_q <= RESULT_RESET;
      res_b_q <= RESULT_RESET;
      eoc_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      cap_a_q <= cap_a_d;
      cap_b_q <= cap_b_d;
      res_a_q <= res_a_d;
      res_b_q <= res_b_d;
      eoc_q   <= eoc_d;
    end
  end

  // handshake outputs, all on the fabric clock
  assign conversion_in_progress = (st_q == ST_CONVERT);
  assign end_of_conversion      = eoc_q;
  assign converter_a_result     = res_a_q;
  assign converter_b_result     = res_b_q;

  // each finished pair enters the buffer with the done pulse
  assign push_if.valid      = eoc_q;
  assign push_if.data       = {res_a_q, res_b_q};
  assign pop_if.ready       = result_ready;
  assign result_valid       = pop_if.valid;
  assign first_result_word  = pop_if.data[2*RESULT_WIDTH-1:RESULT_WIDTH];
  assign second_result_word = pop_if.data[RESULT_WIDTH-1:0];

  // comparators, one slice each
  for (genvar i = 0; i < COMP_COUNT; i++) begin : g_comp
    logic [2:0] s_q, s_d;     // pin synchroniser
    logic       lvl_q, lvl_d; // agreed level
    logic       lat_q, lat_d; // latched result
    logic       raw;          // chosen comparator output

    assign raw = COMPARATOR_SOURCE[i] ? dedicated_compare_raw[i] : channel_compare_raw[i];

    // level follows once second and third flops agree
    always_comb begin
      s_d   = {s_q[1:0], raw};
      lvl_d = (s_q[1] == s_q[2]) ? s_q[2] : lvl_q;
      lat_d = conv_reset ? 1'b0 : (lat_q | lvl_q);
    end

    always_ff @(posedge mclk) begin
      if (srst) begin
        s_q   <= SYNC_RESET;
        lvl_q <= 1'b0;
        lat_q <= 1'b0;
      end else begin
        s_q   <= s_d;
        lvl_q <= lvl_d;
        lat_q <= lat_d;
      end
    end

    assign compare_level[i]   = lvl_q;
    assign compare_latched[i] = lat_q;
  end

  // phase length helper for the timing checks
  logic [BOUND_WIDTH-1:0] samp_len_q, samp_len_d; // cycles in sampling
  logic [BOUND_WIDTH-1:0] conv_len_q, conv_len_d; // cycles converting, start low
  logic [BOUND_WIDTH-1:0] div_eff;                // divider as used

  assign div_eff = BOUND_WIDTH'(div_last) + 1'b1;

  always_comb begin
    samp_len_d = (st_q == ST_SAMPLE) ? samp_len_q + 1'b1 : '0;
    conv_len_d = conv_len_q;
    if (st_q != ST_CONVERT) begin
      conv_len_d = '0;
    end else if (!start_conversion) begin
      conv_len_d = conv_len_q + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      samp_len_q <= '0;
      conv_len_q <= '0;
    end else begin
      samp_len_q <= samp_len_d;
      conv_len_q <= conv_len_d;
    end
  end

  start_take_a: assert property (@(posedge mclk) disable iff (srst)
    (st_q == ST_IDLE && start_conversion && start_ok) |=> st_q == ST_SAMPLE)
    else $error("start not taken");
  busy_after_sample_a: assert property (@(posedge mclk) disable iff (srst)
    $rose(conversion_in_progress) |-> $past(st_q) == ST_SAMPLE && $past(tick_q))
    else $error("busy rose outside sampling");
  done_data_a: assert property (@(posedge mclk) disable iff (srst)
    end_of_conversion |-> converter_a_result == $past(cap_a_q)
      && converter_b_result == $past(cap_b_q) && $fell(conversion_in_progress))
    else $error("results not fresh with done");
  done_single_a: assert property (@(posedge mclk) disable iff (srst)
    end_of_conversion |=> !end_of_conversion ##1 !end_of_conversion)
    else $error("done pulse too long");
  no_restart_a: assert property (@(posedge mclk) disable iff (srst)
    conversion_in_progress |=> st_q != ST_SAMPLE)
    else $error("restart while busy");
  stop_abort_a: assert property (@(posedge mclk) disable iff (srst)
    (conversion_in_progress && stop_conversion) |=> !conversion_in_progress
      && !end_of_conversion && $stable(converter_a_result) && $stable(converter_b_result))
    else $error("stop did not abort cleanly");
  settle_gap_a: assert property (@(posedge mclk) disable iff (srst)
    $fell(conversion_in_progress) |-> (st_q == ST_SETTLE)[*8] ##1 st_q == ST_IDLE)
    else $error("settle time wrong");
  latch_clear_a: assert property (@(posedge mclk) disable iff (srst)
    conv_reset |=> compare_latched == '0 && !calibration_ready)
    else $error("latches not cleared");
  sample_bound_a: assert property (@(posedge mclk) disable iff (srst)
    $stable(converter_clock_divider) |->
      samp_len_q <= BOUND_WIDTH'(SAMPLE_TICKS) * div_eff + BOUND_WIDTH'(SAMPLE_SLACK))
    else $error("sampling phase too long");
  convert_bound_a: assert property (@(posedge mclk) disable iff (srst)
    $stable(converter_clock_divider) |->
      conv_len_q <= BOUND_WIDTH'(CONVERT_TICKS) * div_eff + BOUND_WIDTH'(CONVERT_SLACK))
    else $error("conversion phase too long");
endmodule
`default_nettype wire

/* File: core/result_fifo.sv */
// parameterised first-in first-out buffer for result word pairs
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic mclk,
  input  wire logic srst,
  stream_if.sink    in_port,
  stream_if.source  out_port
);
  import conv_pkg::*;
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];           // storage
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d; // pointers
  logic [AW:0]      cnt_q, cnt_d;           // fill level
  logic             push, pop;              // accepted moves

  // honest full and empty
  assign in_port.ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_port.valid = (cnt_q != '0);
  assign out_port.data  = mem[rd_q];
  assign push = in_port.valid && in_port.ready;
  assign pop  = out_port.valid && out_port.ready;

  // pointer and level next values
  always_comb begin
    wr_d  = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d  = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // pointer and level registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_q] <= in_port.data;
    end
  end

  // a full buffer refuses, a lone push raises the fill level by one
  full_refuse_a: assert property (@(posedge mclk) disable iff (srst)
    cnt_q == (AW+1)'(DEPTH) |-> !in_port.ready)
    else $error("full buffer still ready");
  level_track_a: assert property (@(posedge mclk) disable iff (srst)
    (push && !pop) |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("fill level missed a push");
endmodule
`default_nettype wire

/* File: core/stream_if.sv */
// valid/ready word stream between the sequencer and its result buffer
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int unsigned WIDTH = 8) ();
  logic             valid;  // word offered
  logic             ready;  // word accepted
  logic [WIDTH-1:0] data;   // word
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: testbench/conv_controller_model.sv */
// fabric-side controller model that drives start and stop of the conversion handshake
`timescale 1ns/1ps
`default_nettype none
module conv_controller_model (
  input  wire logic                              mclk,
  input  wire logic                              conversion_in_progress,
  input  wire logic                              end_of_conversion,
  input  wire logic [conv_pkg::RESULT_WIDTH-1:0] converter_a_result,
  input  wire logic [conv_pkg::RESULT_WIDTH-1:0] converter_b_result,
  output logic                                   start_conversion,
  output logic                                   stop_conversion
);
  import conv_pkg::*;
  logic [RESULT_WIDTH-1:0] cap_a;      // captured pair, converter a
  logic [RESULT_WIDTH-1:0] cap_b;      // captured pair, converter b
  int                      quiet = 0;  // cycles since busy was last high

  initial begin
    start_conversion = 1'b0;
    stop_conversion  = 1'b0;
  end

  // count quiet cycles after busy falls, saturating
  always @(posedge mclk) begin
    if (conversion_in_progress === 1'b1) begin
      quiet <= 0;
    end else if (quiet < 100) begin
      quiet <= quiet + 1;
    end
  end

  // hold off a new start until the converter has settled
  task automatic settle();
    for (int i = 0; i < 200 && quiet < 9; i++) @(negedge mclk);
  endtask

  // one full conversion; hold keeps start high beyond busy rising
  task automatic convert(input int hold, output int samp, output int conv, output bit ok);
    ok   = 1'b0;
    samp = 0;
    conv = 0;
    settle();
    start_conversion = 1'b1;
    while (conversion_in_progress !== 1'b1 && samp < 400) begin
      @(negedge mclk);
      samp++;
    end
    if (conversion_in_progress === 1'b1) begin
      // conv counts from busy rising, so held cycles are part of it
      for (int h = 0; h < hold; h++) begin
        @(negedge mclk);
        conv++;
      end
      start_conversion = 1'b0;
      // wait for done before capture, giving up if busy drops early
      while (end_of_conversion !== 1'b1 && conversion_in_progress === 1'b1 && conv < 1000) begin
        @(negedge mclk);
        conv++;
      end
      ok    = (end_of_conversion === 1'b1);
      cap_a = converter_a_result;
      cap_b = converter_b_result;
    end else begin
      start_conversion = 1'b0;
    end
  endtask

  // start a conversion, then abort it part way through
  task automatic abort_run(output bit seen_done, output bit ok);
    int i;
    seen_done = 1'b0;
    ok        = 1'b0;
    i         = 0;
    settle();
    start_conversion = 1'b1;
    while (conversion_in_progress !== 1'b1 && i < 400) begin
      @(negedge mclk);
      i++;
    end
    start_conversion = 1'b0;
    repeat (5) @(negedge mclk);
    ok = (conversion_in_progress === 1'b1);
    stop_conversion = 1'b1;
    i = 0;
    // keep stop high until busy is low
    while (conversion_in_progress !== 1'b0 && i < 50) begin
      @(negedge mclk);
      seen_done = seen_done | (end_of_conversion === 1'b1);
      i++;
    end
    ok = ok && (conversion_in_progress === 1'b0);
    @(negedge mclk);
    stop_conversion = 1'b0;
  endtask

  // stop while still sampling, start kept high; busy and done must stay low
  task automatic sample_stop(output bit seen);
    seen = 1'b0;
    settle();
    start_conversion = 1'b1;
    repeat (3) @(negedge mclk);
    stop_conversion = 1'b1;
    // long enough for settle to end; start_ok takes no start while stop is high, so busy stays low
    repeat (30) begin
      @(negedge mclk);
      seen = seen | (conversion_in_progress !== 1'b0) | (end_of_conversion !== 1'b0);
    end
    start_conversion = 1'b0;
    stop_conversion  = 1'b0;
    @(negedge mclk);
  endtask
endmodule
`default_nettype wire

/* File: testbench/dual_conv_handshake_tb.sv */
// self-checking bench for the paired converter handshake
`timescale 1ns/1ps
`default_nettype none
module dual_conv_handshake_tb;
  import conv_pkg::*;
  logic                    mclk = 1'b0;
  logic                    srst;
  logic [DIV_WIDTH-1:0]    div_setting;
  logic                    start, stop, reset_n, busy, done, cal_rdy, res_valid, result_ready;
  logic [RESULT_WIDTH-1:0] a_sample, b_sample, a_res, b_res, word_a, word_b;
  logic [COMP_COUNT-1:0]   ch_raw, ded_raw, level, latched;
  int                      mismatches = 0;
  int                      comparisons = 0;
  int                      s, c;
  bit                      ok, seen;

  always #2.5 mclk = ~mclk;

  // comparator 1 takes the dedicated input, the others the channel inputs
  dual_conv_handshake #(.COMPARATOR_SOURCE(3'h2)) dut (
    .mclk(mclk), .srst(srst), .converter_clock_divider(div_setting),
    .start_conversion(start), .stop_conversion(stop), .converter_reset_n(reset_n),
    .converter_a_sample(a_sample), .converter_b_sample(b_sample),
    .channel_compare_raw(ch_raw), .dedicated_compare_raw(ded_raw),
    .conversion_in_progress(busy), .end_of_conversion(done),
    .converter_a_result(a_res), .converter_b_result(b_res), .calibration_ready(cal_rdy),
    .compare_level(level), .compare_latched(latched), .result_valid(res_valid),
    .result_ready(result_ready), .first_result_word(word_a), .second_result_word(word_b));

  conv_controller_model model (
    .mclk(mclk), .conversion_in_progress(busy), .end_of_conversion(done),
    .converter_a_result(a_res), .converter_b_result(b_res),
    .start_conversion(start), .stop_conversion(stop));

  task automatic results();
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input bit good, input string msg);
    comparisons++;
    if (!good) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // bounded wait for calibration to finish
  task automatic wait_cal();
    int i;
    i = 0;
    while (cal_rdy !== 1'b1 && i < 500) begin
      @(negedge mclk);
      i++;
    end
    if (cal_rdy !== 1'b1) begin
      chk(1'b0, "calibration never became ready");
      results();
    end
  endtask

  // outputs quiet during reset, then calibration completes
  task automatic t_reset();
    chk(busy === 1'b0 && done === 1'b0 && res_valid === 1'b0, "status not clear in reset");
    chk(a_res === 12'h000 && b_res === 12'h000, "results not clear in reset");
    chk(level === 3'h0 && latched === 3'h0, "comparators not clear in reset");
    srst = 1'b0;
    wait_cal();
  endtask

  // plain conversions at three divider settings
  task automatic t_basic();
    int d;
    int s0, c0;
    for (int k = 0; k < 3; k++) begin
      d           = 1 << k;
      div_setting = DIV_WIDTH'(d);
      a_sample    = 12'h5a0 | RESULT_WIDTH'(k);
      b_sample    = 12'h0c0 | RESULT_WIDTH'(k);
      model.convert(0, s, c, ok);
      chk(ok, "conversion did not end with done while busy");
      chk(s > 9 * d && s <= 10 * d + 6, "sampling phase length");
      chk(c > 33 * d && c <= 34 * d + 16, "conversion phase length");
      chk(model.cap_a === a_sample && model.cap_b === b_sample, "result pair");
      if (k == 0) begin
        s0 = s;
        c0 = c;
      end
    end
    div_setting = 4'h1;
    // ticks come from the fabric clock, so the period repeats exactly
    model.convert(0, s, c, ok);
    chk(ok && s == s0 && c == c0, "sampling period not constant");
  endtask

  // start held past busy: period grows and input keeps being tracked
  task automatic t_hold();
    a_sample = 12'h3c1;
    b_sample = 12'h2d4;
    fork
      model.convert(20, s, c, ok);
      begin
        repeat (22) @(negedge mclk);
        a_sample = 12'h7e4;
        b_sample = 12'h81b;
      end
    join
    chk(ok && c >= 20 + 33, "held start did not lengthen period");
    chk(model.cap_a === 12'h7e4 && model.cap_b === 12'h81b, "held start lost input");
  endtask

  // stop during sampling: no busy, no done, results kept, start held high under stop
  task automatic t_sample_stop();
    model.sample_stop(seen);
    chk(!seen && a_res === 12'h7e4 && b_res === 12'h81b, "stop in sampling not clean");
  endtask

  // abort mid conversion, results kept, restart works
  task automatic t_abort();
    a_sample = 12'h111;
    b_sample = 12'h222;
    model.abort_run(seen, ok);
    chk(ok && !seen, "stop did not abort cleanly");
    repeat (3) @(negedge mclk);
    chk(a_res === 12'h7e4 && b_res === 12'h81b, "results changed by abort");
    model.convert(0, s, c, ok);
    chk(ok && model.cap_a === 12'h111 && model.cap_b === 12'h222, "restart after abort");
  endtask

  // fill the buffer with the consumer stalled, then drain it in order
  task automatic t_fifo();
    // let the pair of the last conversion leave the buffer first
    repeat (2) @(negedge mclk);
    result_ready = 1'b0;
    chk(res_valid === 1'b0, "buffer not empty at start");
    for (int k = 0; k < 8; k++) begin
      a_sample = 12'h800 + RESULT_WIDTH'(k);
      b_sample = 12'h0f0 + RESULT_WIDTH'(k);
      model.convert(0, s, c, ok);
      chk(ok, "conversion while filling buffer");
    end
    model.convert(0, s, c, ok);
    chk(!ok, "conversion taken with full buffer");
    // ready held high: one pop per edge, head checked before each pop
    result_ready = 1'b1;
    for (int k = 0; k < 8; k++) begin
      chk(res_valid === 1'b1 && word_a === 12'h800 + RESULT_WIDTH'(k)
          && word_b === 12'h0f0 + RESULT_WIDTH'(k), "buffer order");
      @(negedge mclk);
    end
    chk(res_valid === 1'b0, "buffer not empty after drain");
  endtask

  // comparator source, level, sticky latch and converter reset
  task automatic t_comp();
    ch_raw  = 3'h7;
    ded_raw = 3'h0;
    repeat (6) @(negedge mclk);
    chk(level === 3'h5 && latched === 3'h5, "comparator set");
    ch_raw = 3'h0;
    repeat (6) @(negedge mclk);
    chk(level === 3'h0 && latched === 3'h5, "latched output not sticky");
    reset_n = 1'b0;
    repeat (6) @(negedge mclk);
    chk(latched === 3'h0 && cal_rdy === 1'b0, "converter reset did not clear");
    reset_n = 1'b1;
    ded_raw = 3'h2;
    repeat (6) @(negedge mclk);
    chk(level === 3'h2 && latched === 3'h2, "dedicated comparator input");
    wait_cal();
  endtask

  initial begin
    srst         = 1'b1;
    reset_n      = 1'b1;
    div_setting  = 4'h1;
    a_sample     = 12'h000;
    b_sample     = 12'h000;
    ch_raw       = 3'h0;
    ded_raw      = 3'h0;
    result_ready = 1'b1;
    repeat (20) @(negedge mclk);
    t_reset();
    t_basic();
    t_hold();
    t_sample_stop();
    t_abort();
    t_fifo();
    t_comp();
    results();
  end
endmodule
`default_nettype wire
